// File: hw/gptu_top.sv
// general purpose timer unit: two timer modules behind a register port
`timescale 1ns/1ps
`default_nettype none
// Contract
// - five 16-bit timers, three in module one, two in module two
// - module-one timers pick timer, gated, counter or incremental mode
// - timer mode counts the cpu clock through a software prescaler
// - counter mode counts external events on the timer input pin
// - gated mode counts prescaled clock only while the gate level allows
// - module-one finest period is eight cpu cycles
// - software direction, optionally flipped by the direction pin
// - incremental mode decodes quadrature A and B into count and direction
// - core one toggle latch inverts on every wrap, may drive a pin
// - core one toggle latch may clock either auxiliary timer
// - auxiliary timer in capture or reload use stops counting
// - capture copies core one into the auxiliary on its input pin
// - reload loads core one from auxiliary on pin or latch transition
// - opposite latch transitions alternate two reload values for pwm
// - module-two finest period is four cpu cycles
// - module-two timers use a prescaler and software direction
// - core two toggle latch inverts on wrap and may clock aux c
// - core two wrap may reload it from the capture reload register
// - capture pin edge latches aux c, optionally clearing it after
// - core one input or direction pin edges may trigger capture
module gptu_top import gptu_pkg::*; #(
  parameter int M1_BASE_DIV = M1_MIN_DIV,
  parameter int M2_BASE_DIV = M2_MIN_DIV
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DW-1:0] reg_rdata_o,
  input wire logic [2:0] timer_input_pin_i,
  input wire logic [2:0] timer_direction_pin_i,
  input wire logic capture_input_pin_i,
  output logic toggle_latch_output_pin_o,
  output logic toggle_pin_oe_n_o,
  output logic [N_IRQ-1:0] irq_req_o
);

  if ($countones(M1_BASE_DIV) != 1 || $countones(M2_BASE_DIV) != 1 ||
      (M1_BASE_DIV << 7) > (1 << PSC_W) ||
      (M2_BASE_DIV << 3) > (1 << PSC_W)) begin : g_bad_div
    $error("prescaler bases must be powers of two within range");
  end

  // one tick every base << sel cycles of the free prescaler
  function automatic logic psc_tick(input logic [PSC_W-1:0] cnt,
                                    input int base, input logic [2:0] sel);
    logic [PSC_W-1:0] m;
    m = PSC_W'((base << sel) - 1);
    return (cnt & m) == m;
  endfunction

  // one count step, carry marks the wrap
  function automatic logic [DW:0] step(input logic [DW-1:0] v,
                                       input logic dn);
    if (dn) return {v == CNT_RST, DW'(v - 1'b1)};
    return {&v, DW'(v + 1'b1)};
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] base, input int k);
    return a == ADDR_W'(int'(base) + k);
  endfunction

  logic [DW-1:0] ctl1_q [3];
  logic [DW-1:0] cnt1_q [3];
  logic [DW-1:0] ctl_c_q, ctl_core2_q, cnt_c_q, cnt_core2_q, capture_reload_register_q;
  logic [N_IRQ-1:0] flag_q, en_q, irq_q, irq_set;
  logic [PSC_W-1:0] psc_q;
  logic lat1_q, lat2_q, oe_n_q;
  logic [DW-1:0] rdata_q;
  logic [2:0] in_s1, in_s2, in_s3, dir_s1, dir_s2, dir_s3;
  logic cap_s1, cap_s2, cap_s3;
  logic [2:0] inc1, carry1, wrap1, dn1, rld1, cap1;
  logic [DW-1:0] nxt1 [3];
  logic [DW:0] st_c, st_core2;
  logic inc_c, inc_core2, wrap_c, wrap_core2, cap_ev;
  gptu_m1_ctl_t c;
  gptu_m2_ctl_t cc, c2;
  // typed views of the module one control words
  gptu_m1_ctl_t ctl_a_v, ctl_core1_v, ctl_b_v;
  logic c_core1_fast;

  assign ctl_a_v = gptu_m1_ctl_t'(ctl1_q[0]);
  assign ctl_core1_v = gptu_m1_ctl_t'(ctl1_q[1]);
  assign ctl_b_v = gptu_m1_ctl_t'(ctl1_q[2]);
  // core one in plain timer mode at its finest period
  assign c_core1_fast = ctl_core1_v.mode == M1_TIMER &&
                        ctl_core1_v.psc == 3'h0;

  // two-stage pin synchronisers, third stage for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {in_s1, in_s2, in_s3} <= '0;
      {dir_s1, dir_s2, dir_s3} <= '0;
      {cap_s1, cap_s2, cap_s3} <= '0;
    end else begin
      in_s1 <= timer_input_pin_i;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      dir_s1 <= timer_direction_pin_i;
      dir_s2 <= dir_s1;
      dir_s3 <= dir_s2;
      cap_s1 <= capture_input_pin_i;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // free running prescaler shared by all timers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) psc_q <= '0;
    else psc_q <= PSC_W'(psc_q + 1'b1);
  end

  // module one count enables, core first so aux timers see its wrap
  always_comb begin
    int i;
    logic pre, a_edge, b_edge;
    c = gptu_m1_ctl_t'(CTL_RST);
    i = 0;
    pre = 1'b0;
    a_edge = 1'b0;
    b_edge = 1'b0;
    for (int j = 0; j < 3; j++) begin
      i = (j == 0) ? 1 : ((j == 1) ? 2 : 0);
      c = gptu_m1_ctl_t'(ctl1_q[i]);
      pre = psc_tick(psc_q, M1_BASE_DIV, c.psc);
      a_edge = in_s2[i] ^ in_s3[i];
      b_edge = dir_s2[i] ^ dir_s3[i];
      dn1[i] = c.down ^ (c.ext_dir & dir_s2[i]);
      rld1[i] = 1'b0;
      cap1[i] = 1'b0;
      unique case (c.mode)
        M1_TIMER: inc1[i] = pre;
        M1_GATED: inc1[i] = pre & (in_s2[i] == c.gate_lvl);
        M1_COUNTER: inc1[i] = in_s2[i] & ~in_s3[i];
        M1_INCR: begin
          inc1[i] = a_edge | b_edge;
          dn1[i] = c.down ^ (a_edge ? (in_s2[i] == dir_s2[i])
                                    : (in_s2[i] != dir_s2[i]));
        end
      endcase
      if (i != 1) begin
        unique case (c.aux_fn)
          AUX_NORMAL: ;
          AUX_LATCH_CLK: inc1[i] = wrap1[1];
          AUX_CAPTURE: begin
            inc1[i] = 1'b0;
            cap1[i] = in_s2[i] & ~in_s3[i];
          end
          AUX_RELOAD: begin
            inc1[i] = 1'b0;
            unique case (c.rtrig)
              RT_PIN: rld1[i] = in_s2[i] & ~in_s3[i];
              RT_RISE: rld1[i] = wrap1[1] & ~lat1_q;
              RT_FALL: rld1[i] = wrap1[1] & lat1_q;
              RT_BOTH: rld1[i] = wrap1[1];
            endcase
          end
        endcase
      end
      inc1[i] = inc1[i] & c.run;
      {carry1[i], nxt1[i]} = step(cnt1_q[i], dn1[i]);
      wrap1[i] = inc1[i] & carry1[i];
    end
  end

  // module one counters: software write, then load, then count
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < 3; i++) begin
      if (srst_i) cnt1_q[i] <= CNT_RST;
      else if (reg_we_i && hit(reg_addr_i, REG_CNT_A, i))
        cnt1_q[i] <= reg_wdata_i;
      else if (i == 1 && rld1[0]) cnt1_q[i] <= cnt1_q[0];
      else if (i == 1 && rld1[2]) cnt1_q[i] <= cnt1_q[2];
      else if (cap1[i]) cnt1_q[i] <= cnt1_q[1];
      else if (inc1[i]) cnt1_q[i] <= nxt1[i];
    end
  end

  // core one toggle latch and its pin
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      lat1_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      if (wrap1[1]) lat1_q <= ~lat1_q;
      oe_n_q <= ~ctl_core1_v.toggle_oe;
    end
  end

  // module two count enables and capture trigger
  always_comb begin
    logic pin_ev;
    cc = gptu_m2_ctl_t'(ctl_c_q);
    c2 = gptu_m2_ctl_t'(ctl_core2_q);
    inc_core2 = c2.run & psc_tick(psc_q, M2_BASE_DIV, {1'b0, c2.psc});
    st_core2 = step(cnt_core2_q, c2.down);
    wrap_core2 = inc_core2 & st_core2[DW];
    inc_c = cc.run & (cc.latch_clk ? wrap_core2
                      : psc_tick(psc_q, M2_BASE_DIV, {1'b0, cc.psc}));
    st_c = step(cnt_c_q, cc.down);
    wrap_c = inc_c & st_c[DW];
    pin_ev = (cc.cap_edge[0] & cap_s2 & ~cap_s3) |
             (cc.cap_edge[1] & ~cap_s2 & cap_s3);
    unique case (cc.cap_src)
      2'h0: cap_ev = pin_ev;
      2'h1: cap_ev = in_s2[1] ^ in_s3[1];
      2'h2: cap_ev = dir_s2[1] ^ dir_s3[1];
      2'h3: cap_ev = (in_s2[1] ^ in_s3[1]) | (dir_s2[1] ^ dir_s3[1]);
    endcase
  end

  // module two counters, capture register and toggle latch
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_core2_q <= CNT_RST;
      cnt_c_q <= CNT_RST;
      capture_reload_register_q <= CNT_RST;
      lat2_q <= 1'b0;
    end else begin
      if (reg_we_i && reg_addr_i == REG_CNT_CORE2)
        cnt_core2_q <= reg_wdata_i;
      else if (wrap_core2 && c2.rld_en) cnt_core2_q <= capture_reload_register_q;
      else if (inc_core2) cnt_core2_q <= st_core2[DW-1:0];
      if (reg_we_i && reg_addr_i == REG_CNT_C) cnt_c_q <= reg_wdata_i;
      else if (cap_ev && cc.clr_after) cnt_c_q <= CNT_RST;
      else if (inc_c) cnt_c_q <= st_c[DW-1:0];
      if (reg_we_i && reg_addr_i == REG_CAP_RELOAD) capture_reload_register_q <= reg_wdata_i;
      else if (cap_ev) capture_reload_register_q <= cnt_c_q;
      if (wrap_core2) lat2_q <= ~lat2_q;
    end
  end

  // control and enable registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < 3; i++) ctl1_q[i] <= CTL_RST;
      ctl_c_q <= CTL_RST;
      ctl_core2_q <= CTL_RST;
      en_q <= IRQ_RST;
    end else if (reg_we_i) begin
      for (int i = 0; i < 3; i++)
        if (hit(reg_addr_i, REG_CTL_A, i)) ctl1_q[i] <= reg_wdata_i;
      if (reg_addr_i == REG_CTL_C) ctl_c_q <= reg_wdata_i;
      if (reg_addr_i == REG_CTL_CORE2) ctl_core2_q <= reg_wdata_i;
      if (reg_addr_i == REG_IRQ_EN) en_q <= reg_wdata_i[N_IRQ-1:0];
    end
  end

  // sticky request flags, write one to clear, a new event wins
  assign irq_set = {cap_ev, wrap_core2, wrap_c, wrap1};
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      flag_q <= IRQ_RST;
      irq_q <= IRQ_RST;
    end else begin
      flag_q <= (flag_q & ~((reg_we_i && reg_addr_i == REG_IRQ_FLAG)
                 ? reg_wdata_i[N_IRQ-1:0] : IRQ_RST)) | irq_set;
      irq_q <= flag_q & en_q;
    end
  end

  // read data in the cycle after the read strobe only
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !reg_re_i) rdata_q <= '0;
    else begin
      unique case (reg_addr_i)
        REG_CTL_A: rdata_q <= ctl1_q[0];
        REG_CTL_CORE1: rdata_q <= ctl1_q[1];
        REG_CTL_B: rdata_q <= ctl1_q[2];
        REG_CTL_C: rdata_q <= ctl_c_q;
        REG_CTL_CORE2: rdata_q <= ctl_core2_q;
        REG_CNT_A: rdata_q <= cnt1_q[0];
        REG_CNT_CORE1: rdata_q <= cnt1_q[1];
        REG_CNT_B: rdata_q <= cnt1_q[2];
        REG_CNT_C: rdata_q <= cnt_c_q;
        REG_CNT_CORE2: rdata_q <= cnt_core2_q;
        REG_CAP_RELOAD: rdata_q <= capture_reload_register_q;
        REG_IRQ_FLAG: rdata_q <= {{(DW-N_IRQ){1'b0}}, flag_q};
        REG_IRQ_EN: rdata_q <= {{(DW-N_IRQ){1'b0}}, en_q};
        default: rdata_q <= '0; // unmapped reads zero
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;
  assign toggle_latch_output_pin_o = lat1_q;
  assign toggle_pin_oe_n_o = oe_n_q;
  assign irq_req_o = irq_q;

  // checks beside the logic
  chk_core1_toggle: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) wrap1[1] |=> lat1_q != $past(lat1_q))
    else $error("core one latch missed a wrap");
  chk_m1_resolution: assert property (@(posedge clk_sys_i)
    disable iff (srst_i || reg_we_i)
    (inc1[1] && c_core1_fast) |=> !inc1[1] [*7] ##1 inc1[1])
    else $error("core one fastest tick not every eight cycles");
  chk_m2_resolution: assert property (@(posedge clk_sys_i)
    disable iff (srst_i || reg_we_i)
    (inc_core2 && c2.psc == 2'h0) |-> ##4 inc_core2)
    else $error("core two fastest tick not every four cycles");
  chk_aux_stopped: assert property (@(posedge clk_sys_i)
    disable iff (srst_i)
    ctl_a_v.aux_fn inside {AUX_CAPTURE, AUX_RELOAD}
      |-> !inc1[0])
    else $error("aux a counted while capture or reload");
  chk_capture_copy: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) (cap1[2] && !reg_we_i)
      |=> cnt1_q[2] == $past(cnt1_q[1]))
    else $error("aux b capture lost core one value");
  chk_reload_core1: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) (rld1[0] && !reg_we_i)
      |=> cnt1_q[1] == $past(cnt1_q[0]))
    else $error("core one reload from aux a wrong");
  chk_core2_reload: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) (wrap_core2 && c2.rld_en && !reg_we_i)
      |=> cnt_core2_q == $past(capture_reload_register_q))
    else $error("core two reload from capture register wrong");
  chk_capture_reload_register_latch: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) (cap_ev && !reg_we_i)
      |=> capture_reload_register_q == $past(cnt_c_q))
    else $error("capture register missed aux c value");
  chk_wrap_up: assert property (@(posedge clk_sys_i)
    disable iff (srst_i)
    (inc_core2 && !c2.down && !c2.rld_en && &cnt_core2_q && !reg_we_i)
      |=> cnt_core2_q == CNT_RST)
    else $error("core two did not wrap to zero");
  chk_irq_flag_set: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) irq_set[IRQ_CORE1] |=> flag_q[IRQ_CORE1] ##1
      (irq_req_o[IRQ_CORE1] == $past(en_q[IRQ_CORE1])))
    else $error("core one flag or request wrong");
  cov_pwm_reload: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    rld1[0] ##[1:1000] rld1[2]);
  cov_capture_clear: cover property (@(posedge clk_sys_i)
    disable iff (srst_i) cap_ev && cc.clr_after);
  cov_incremental: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    inc1[1] && ctl_core1_v.mode == M1_INCR);
  // core two latch follows every wrap of core two
  chk_core2_toggle: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) wrap_core2 |=> lat2_q != $past(lat2_q))
    else $error("core two latch missed a wrap");
  // core one input pin edges reach the capture register
  chk_alt_capture: assert property (@(posedge clk_sys_i)
    disable iff (srst_i)
    (cc.cap_src == 2'h1 && in_s2[1] != in_s3[1]) |-> cap_ev)
    else $error("core one input edge did not trigger capture");
  // aux b clocked by core one wraps only
  chk_latch_clock: assert property (@(posedge clk_sys_i)
    disable iff (srst_i)
    (ctl_b_v.aux_fn == AUX_LATCH_CLK && ctl_b_v.run) |-> inc1[2] == wrap1[1])
    else $error("aux b latch clock wrong");
  cov_latch_clock: cover property (@(posedge clk_sys_i)
    disable iff (srst_i) inc1[2] && ctl_b_v.aux_fn == AUX_LATCH_CLK);

endmodule // gptu_top
`default_nettype wire

// File: hw/gptu_pkg.sv
// constants, control layouts and types of the general purpose timer unit
package gptu_pkg;
  localparam int DW = 16;
  localparam int ADDR_W = 4;
  localparam int PSC_W = 16;
  localparam int N_IRQ = 6;
  // register indices on the plain register port
  localparam logic [3:0] REG_CTL_A = 4'h0;
  localparam logic [3:0] REG_CTL_CORE1 = 4'h1;
  localparam logic [3:0] REG_CTL_B = 4'h2;
  localparam logic [3:0] REG_CTL_C = 4'h3;
  localparam logic [3:0] REG_CTL_CORE2 = 4'h4;
  localparam logic [3:0] REG_CNT_A = 4'h5;
  localparam logic [3:0] REG_CNT_CORE1 = 4'h6;
  localparam logic [3:0] REG_CNT_B = 4'h7;
  localparam logic [3:0] REG_CNT_C = 4'h8;
  localparam logic [3:0] REG_CNT_CORE2 = 4'h9;
  localparam logic [3:0] REG_CAP_RELOAD = 4'ha;
  localparam logic [3:0] REG_IRQ_FLAG = 4'hb;
  localparam logic [3:0] REG_IRQ_EN = 4'hc;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [5:0] IRQ_RST = 6'h00;
  // interrupt flag positions
  localparam int IRQ_A = 0;
  localparam int IRQ_CORE1 = 1;
  localparam int IRQ_B = 2;
  localparam int IRQ_C = 3;
  localparam int IRQ_CORE2 = 4;
  localparam int IRQ_CAP = 5;
  // finest count periods, derived into cpu cycles
  localparam int CPU_REF_MHZ = 16;
  localparam int M1_RES_NS = 500;
  localparam int M2_RES_NS = 250;
  localparam int M1_MIN_DIV = M1_RES_NS * CPU_REF_MHZ / 1000;
  localparam int M2_MIN_DIV = M2_RES_NS * CPU_REF_MHZ / 1000;

  typedef enum logic [1:0] {
    M1_TIMER = 2'h0, M1_GATED = 2'h1, M1_COUNTER = 2'h3, M1_INCR = 2'h2
  } gptu_mode_t;
  typedef enum logic [1:0] {
    AUX_NORMAL = 2'h0, AUX_LATCH_CLK = 2'h1, AUX_RELOAD = 2'h3,
    AUX_CAPTURE = 2'h2
  } gptu_aux_t;
  typedef enum logic [1:0] {
    RT_PIN = 2'h0, RT_RISE = 2'h1, RT_BOTH = 2'h3, RT_FALL = 2'h2
  } gptu_rtrig_t;

  typedef struct packed {
    logic [1:0] rsvd;
    gptu_rtrig_t rtrig;
    gptu_aux_t aux_fn;
    logic toggle_oe;
    logic ext_dir;
    logic down;
    logic run;
    logic gate_lvl;
    gptu_mode_t mode;
    logic [2:0] psc;
  } gptu_m1_ctl_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [1:0] cap_edge;
    logic [1:0] cap_src;
    logic clr_after;
    logic rld_en;
    logic latch_clk;
    logic down;
    logic run;
    logic [1:0] psc;
  } gptu_m2_ctl_t;
endpackage

// File: testbench/gptu_pin_model.sv
// external event, gate, capture and quadrature sensor pin model
`timescale 1ns/1ps
`default_nettype none
module gptu_pin_model (
  input wire logic clk_i,
  output logic [2:0] in_pin_o,
  output logic [2:0] dir_pin_o,
  output logic cap_pin_o
);
  // levels held well past the two-flop synchroniser
  localparam int HOLD = 4;
  initial begin
    in_pin_o = 3'h0;
    dir_pin_o = 3'h0;
    cap_pin_o = 1'b0;
  end
  // clean event pulses on one timer input pin
  task pulse_in(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_i);
      in_pin_o[idx] <= 1'b1;
      repeat (HOLD) @(posedge clk_i);
      in_pin_o[idx] <= 1'b0;
      repeat (HOLD) @(posedge clk_i);
    end
  endtask
  // static gate or direction levels
  task set_pin(input int idx, input logic in_v, input logic dir_v);
    @(posedge clk_i);
    in_pin_o[idx] <= in_v;
    dir_pin_o[idx] <= dir_v;
    repeat (HOLD) @(posedge clk_i);
  endtask
  // one rising then falling edge on the capture pin
  task pulse_cap();
    @(posedge clk_i);
    cap_pin_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    cap_pin_o <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
  endtask
  // gray steps, signal a on the input pin, b on the direction pin
  task quad(input int idx, input int n, input logic fwd);
    repeat (n) begin
      @(posedge clk_i);
      if ((in_pin_o[idx] == dir_pin_o[idx]) == fwd) begin
        in_pin_o[idx] <= ~in_pin_o[idx];
      end else begin
        dir_pin_o[idx] <= ~dir_pin_o[idx];
      end
      repeat (HOLD) @(posedge clk_i);
    end
  endtask
endmodule // gptu_pin_model
`default_nettype wire

// File: testbench/gptu_top_tb_top.sv
// self-checking bench for the general purpose timer unit
`timescale 1ns/1ps
`default_nettype none
module gptu_top_tb_top import gptu_pkg::*;;
  localparam int D1 = 8;
  localparam int D2 = 4;
  logic clk_sys_i;
  logic srst_i;
  logic [ADDR_W-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic [DW-1:0] reg_rdata;
  logic reg_we;
  logic reg_re;
  logic [2:0] in_pin;
  logic [2:0] dir_pin;
  logic cap_pin;
  logic tog_pin;
  logic tog_oe_n;
  logic [N_IRQ-1:0] irq_req;
  logic [DW-1:0] v0;
  logic [DW-1:0] v1;
  int bad_count;
  int checks;
  gptu_top #(.M1_BASE_DIV(D1), .M2_BASE_DIV(D2)) u_gptu_top (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata), .timer_input_pin_i(in_pin),
    .timer_direction_pin_i(dir_pin), .capture_input_pin_i(cap_pin),
    .toggle_latch_output_pin_o(tog_pin), .toggle_pin_oe_n_o(tog_oe_n),
    .irq_req_o(irq_req)
  );
  gptu_pin_model u_gptu_pin_model (
    .clk_i(clk_sys_i), .in_pin_o(in_pin), .dir_pin_o(dir_pin),
    .cap_pin_o(cap_pin)
  );
  // 50 mhz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // counts and verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [DW-1:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b", $time, m, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys_i);
    reg_we <= 1'b0;
  endtask
  // one-cycle read strobe, data in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys_i);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // counter advance over exactly n cycles
  task automatic span(input logic [ADDR_W-1:0] a, input int n,
                      output logic [DW-1:0] d);
    rd(a, v0);
    repeat (n - 2) @(posedge clk_sys_i);
    rd(a, v1);
    d = v1 - v0;
  endtask
  // run one timer for 80 cycles and compare its advance
  task automatic rate(input logic [ADDR_W-1:0] ca, na,
                      input logic [DW-1:0] ctl, exp);
    wr(ca, ctl);
    span(na, 80, v0);
    chk_word(v0, exp, "count rate");
    wr(ca, 16'h0000);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    $display("unexpected at %0t: run hung", $time);
    end_sim();
  end
  initial begin
    srst_i = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    // indices 0 to 13 read zero after reset, unmapped index 13 too
    for (int a = 0; a < 14; a++) begin
      rd(4'(a), v0);
      chk_word(v0, 16'h0000, "reset value");
    end
    @(posedge clk_sys_i);
    #1 chk_word(reg_rdata, 16'h0000, "idle read data");
    chk_bit(tog_oe_n, 1'b1, "pin enable idle");
    // core one counts down through zero
    wr(REG_CTL_CORE1, 16'h02c0);
    repeat (12) @(posedge clk_sys_i);
    wr(REG_CTL_CORE1, 16'h0200);
    rd(REG_CNT_CORE1, v0);
    chk_word({v0[15:8], 8'h00}, 16'hff00, "down wrap");
    rd(REG_IRQ_FLAG, v0);
    chk_word(v0, 16'h0002, "wrap flag");
    chk_bit(tog_pin, 1'b1, "toggle latch");
    chk_bit(tog_oe_n, 1'b0, "pin enable");
    wr(REG_IRQ_EN, 16'h0002);
    @(posedge clk_sys_i);
    #1 chk_bit(irq_req[IRQ_CORE1], 1'b1, "request raised");
    wr(REG_IRQ_FLAG, 16'h0002);
    @(posedge clk_sys_i);
    #1 chk_bit(irq_req[IRQ_CORE1], 1'b0, "request cleared");
    // prescaled rates and directions
    rate(REG_CTL_CORE1, REG_CNT_CORE1, 16'h0040, DW'(80 / D1));
    rate(REG_CTL_CORE1, REG_CNT_CORE1, 16'h0041, DW'(40 / D1));
    u_gptu_pin_model.set_pin(1, 1'b0, 1'b1);
    rate(REG_CTL_CORE1, REG_CNT_CORE1, 16'h0140, DW'(-80 / D1));
    rate(REG_CTL_CORE2, REG_CNT_CORE2, 16'h0004, DW'(80 / D2));
    rate(REG_CTL_CORE2, REG_CNT_CORE2, 16'h000d, DW'(-40 / D2));
    // counter mode on external events
    wr(REG_CNT_A, 16'h0000);
    wr(REG_CTL_A, 16'h0058);
    u_gptu_pin_model.pulse_in(0, 5);
    rd(REG_CNT_A, v0);
    chk_word(v0, 16'h0005, "event count");
    // gated mode closed, then open
    rate(REG_CTL_A, REG_CNT_A, 16'h0068, 16'h0000);
    u_gptu_pin_model.set_pin(0, 1'b1, 1'b0);
    rate(REG_CTL_A, REG_CNT_A, 16'h0068, DW'(80 / D1));
    // quadrature forward then back
    wr(REG_CNT_B, 16'h0000);
    wr(REG_CTL_B, 16'h0050);
    u_gptu_pin_model.quad(2, 4, 1'b1);
    rd(REG_CNT_B, v0);
    chk_word(v0, 16'h0004, "quad forward");
    u_gptu_pin_model.quad(2, 6, 1'b0);
    rd(REG_CNT_B, v0);
    chk_word(v0, 16'hfffe, "quad back");
    // capture pin rising edge with clear
    wr(REG_CNT_C, 16'h1234);
    wr(REG_CTL_C, 16'h0240);
    wr(REG_CTL_CORE2, 16'h0240);
    u_gptu_pin_model.pulse_cap();
    rd(REG_CAP_RELOAD, v0);
    chk_word(v0, 16'h1234, "capture value");
    rd(REG_CNT_C, v0);
    chk_word(v0, 16'h0000, "clear after capture");
    rd(REG_IRQ_FLAG, v0);
    chk_bit(v0[IRQ_CAP], 1'b1, "capture flag");
    // capture from core one input pin, no clear
    wr(REG_CNT_C, 16'h00a5);
    wr(REG_CTL_C, 16'h0280);
    wr(REG_CTL_CORE2, 16'h0280);
    u_gptu_pin_model.pulse_in(1, 1);
    rd(REG_CAP_RELOAD, v0);
    chk_word(v0, 16'h00a5, "alt capture");
    rd(REG_CNT_C, v0);
    chk_word(v0, 16'h00a5, "no clear");
    // core two reloads on wrap
    wr(REG_CTL_C, 16'h0000);
    wr(REG_CAP_RELOAD, 16'hfff0);
    wr(REG_CNT_CORE2, 16'hfffe);
    wr(REG_CTL_CORE2, 16'h0024);
    repeat (12) @(posedge clk_sys_i);
    wr(REG_CTL_CORE2, 16'h0000);
    rd(REG_CNT_CORE2, v0);
    chk_word({v0[15:4], 4'h0}, 16'hfff0, "reload on wrap");
    // aux b clocked by one core one wrap
    wr(REG_CNT_CORE1, 16'h0000);
    wr(REG_CTL_B, 16'h0440);
    wr(REG_CNT_B, 16'h0000);
    wr(REG_CTL_CORE1, 16'h00c0);
    repeat (12) @(posedge clk_sys_i);
    wr(REG_CTL_CORE1, 16'h0000);
    rd(REG_CNT_B, v0);
    chk_word(v0, 16'h0001, "latch clocked aux");
    // aux b captures core one, pin left high, so two pulses
    wr(REG_CTL_B, 16'h0800);
    wr(REG_CNT_CORE1, 16'h4321);
    u_gptu_pin_model.pulse_in(2, 2);
    rd(REG_CNT_B, v0);
    chk_word(v0, 16'h4321, "aux capture");
    // core one reloaded from aux a on its pin, pin left high
    wr(REG_CNT_A, 16'h0777);
    wr(REG_CTL_A, 16'h0c00);
    u_gptu_pin_model.pulse_in(0, 2);
    rd(REG_CNT_CORE1, v0);
    chk_word(v0, 16'h0777, "pin reload");
    end_sim();
  end
endmodule // gptu_top_tb_top
`default_nettype wire
